/* File: hdl/cpu_branch_pkg.sv */
// Shared types, constants and address helpers for the branch and state control core
package cpu_branch_pkg;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_MIDDLE, MODE_ADVANCED, MODE_MAXIMUM} cpu_mode_type;

    typedef enum logic [2:0] {OP_JUMP_IND8, OP_CALL_IND8, OP_JUMP_EXT7, OP_CALL_EXT7,
                              OP_LEA} op_kind_type;

    typedef enum logic [1:0] {PTR_IND8, PTR_EXT7, PTR_VECTOR} ptr_sel_type;

    typedef enum logic [2:0] {PS_RESET, PS_EXCEPTION, PS_EXECUTE, PS_BUS_RELEASED,
                              PS_STOP} proc_state_type;

    localparam logic [31:0] EA16_MASK    = 32'h0000_ffff;
    localparam logic [31:0] PTR24_MASK   = 32'h00ff_ffff;
    localparam logic [31:0] EXT7_OFFSET  = 32'h0000_0080;
    localparam logic [7:0]  VEC_RESET    = 8'h00;
    localparam logic [7:0]  VEC_ADDR_ERR = 8'h09;
    localparam logic [31:0] PC_RESET     = 32'h0000_0000;
    localparam int          WORD_SHIFT   = 1;
    localparam int          LONG_SHIFT   = 2;

    function automatic logic is_normal(input cpu_mode_type m);
        return m == MODE_NORMAL;
    endfunction : is_normal

    // Normal mode drops the upper 16 bits and keeps a 16-bit address
    function automatic logic [31:0] trunc_ea(input cpu_mode_type m, input logic [31:0] ea);
        return is_normal(m) ? (ea & EA16_MASK) : ea;
    endfunction : trunc_ea

    // Fetched pointer to branch target
    function automatic logic [31:0] fmt_pointer(input cpu_mode_type m,
                                                input logic [31:0] rdata);
        if (is_normal(m))
        begin
            return rdata & EA16_MASK;
        end
        else if (m == MODE_MAXIMUM)
        begin
            return rdata;
        end
        return rdata & PTR24_MASK;
    endfunction : fmt_pointer

    // Table slot to byte address: word slots in normal mode, longword slots otherwise
    function automatic logic [31:0] scale_ptr(input cpu_mode_type m, input logic [31:0] x);
        return is_normal(m) ? (x << WORD_SHIFT) : (x << LONG_SHIFT);
    endfunction : scale_ptr

endpackage : cpu_branch_pkg

/* File: hdl/ptr_address_gen.sv */
// Pointer location for memory-indirect branches and exception vectors
`timescale 1ns/1ps
`default_nettype none
module ptr_address_gen
    import cpu_branch_pkg::*;
(
    input  wire cpu_branch_pkg::cpu_mode_type cpu_mode,
    input  wire cpu_branch_pkg::ptr_sel_type  sel,
    input  wire logic [7:0]                   field,
    input  wire logic [31:0]                  vector_base_reg,
    output logic [31:0]                       ptr_addr,
    output logic                              ptr_long
);
    logic [31:0] raw;
    logic        fixed_vec;

    always_comb
    begin
        fixed_vec = (field == VEC_RESET) || (field == VEC_ADDR_ERR);
        case (sel)
            PTR_IND8:   raw = {24'h000000, field};
            PTR_EXT7:   raw = scale_ptr(cpu_mode, {25'h0, field[6:0]} + EXT7_OFFSET);
            PTR_VECTOR: raw = scale_ptr(cpu_mode, {24'h000000, field})
                              + (fixed_vec ? 32'h0000_0000 : vector_base_reg);
            default:    raw = 32'h0000_0000;
        endcase
        ptr_addr = trunc_ea(cpu_mode, raw);
        ptr_long = !is_normal(cpu_mode);
    end
endmodule : ptr_address_gen
`default_nettype wire

/* File: hdl/lea_unit.sv */
// Effective address computation for the load-effective-address operation
`timescale 1ns/1ps
`default_nettype none
module lea_unit
    import cpu_branch_pkg::*;
(
    input  wire cpu_branch_pkg::cpu_mode_type cpu_mode,
    input  wire logic [31:0]                  reg_operand,
    input  wire logic [31:0]                  disp,
    input  wire logic [1:0]                   scale,
    output logic [31:0]                       ea
);
    logic [31:0] scaled;

    always_comb
    begin
        // Register-direct operand stands in for the index register
        scaled = reg_operand << scale;
        ea     = trunc_ea(cpu_mode, disp + scaled);
    end
endmodule : lea_unit
`default_nettype wire

/* File: hdl/cpu_indirect_branch_and_state_control.sv */
// Processing-state sequencer with memory-indirect branch and address generation
// Functional notes
// - Indirect pointer location comes from the 8-bit field of the instruction.
// - Upper address bits of that pointer location are zero: range 0 to 255.
// - Normal mode fetches word pointers, 16-bit targets; other modes fetch longwords.
// - Middle and advanced modes force the top byte of longword pointers to zero.
// - Vectors are offset by the vector base, except reset and address error.
// - Extended pointer address is (7-bit field plus 0x80) times 2 or 4.
// - Extended pointers lie in 0x100-0x1ff normal, 0x200-0x3ff otherwise.
// - Normal mode truncates every effective address to 16 bits.
// - Load-effective-address writes the address to a register, no memory access.
// - Register-direct operand serves as index of the indexed-displacement sum.
// - Five main states: reset, exception, execute, bus released, stop.
// - Reset input low aborts everything and enters reset at once.
// - Core and peripherals stay initialised and stopped in reset.
// - All interrupts are masked throughout reset.
// - Reset exception handling starts once the reset input rises.
// - Watchdog overflow also forces the reset state.
// - Exceptions fetch a vector from the table and branch to it.
// - Bus request releases the bus and halts until it is returned.
// - Sleep or hardware standby enters the stop state, execution ceases.
`timescale 1ns/1ps
`default_nettype none
module cpu_indirect_branch_and_state_control
    import cpu_branch_pkg::*;
(
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    input  wire cpu_branch_pkg::cpu_mode_type   cpu_mode,
    input  wire logic                           wdt_overflow,
    input  wire logic                           exc_req,
    input  wire logic [7:0]                     exc_vector,
    input  wire logic [31:0]                    vector_base_reg,
    input  wire logic                           op_valid,
    input  wire cpu_branch_pkg::op_kind_type    op_kind,
    input  wire logic [7:0]                     op_field,
    input  wire logic [3:0]                     op_len,
    input  wire logic [31:0]                    lea_index,
    input  wire logic [31:0]                    lea_disp,
    input  wire logic [1:0]                     lea_scale,
    input  wire logic [3:0]                     lea_dst,
    input  wire logic                           mem_ack,
    input  wire logic [31:0]                    mem_rdata,
    input  wire logic                           bus_req,
    input  wire logic                           sleep_req,
    input  wire logic                           hw_standby,
    output logic                                op_ready,
    output logic                                mem_req,
    output logic [31:0]                         mem_addr,
    output logic                                mem_long,
    output logic                                bus_grant,
    output logic                                branch_valid,
    output logic                                branch_call,
    output logic [31:0]                         pc,
    output logic                                reg_wr_en,
    output logic [3:0]                          reg_wr_idx,
    output logic [31:0]                         reg_wr_data,
    output logic                                irq_mask,
    output logic                                periph_reset,
    output cpu_branch_pkg::proc_state_type      proc_state
);
    typedef enum logic [2:0] {ST_RESET, ST_VEC_FETCH, ST_EXECUTE, ST_PTR_FETCH,
                              ST_BUS_RELEASED, ST_STOP} seq_state_type;

    seq_state_type  state_reg,        state_next;
    logic [31:0]    pc_reg,           pc_next;
    logic [31:0]    mem_addr_reg,     mem_addr_next;
    logic           mem_long_reg,     mem_long_next;
    logic           mem_req_reg,      mem_req_next;
    logic           ptr_ext_reg,      ptr_ext_next;
    logic           branch_call_reg,  branch_call_next;
    logic           branch_valid_reg, branch_valid_next;
    logic           reg_wr_en_reg,    reg_wr_en_next;
    logic [3:0]     reg_wr_idx_reg,   reg_wr_idx_next;
    logic [31:0]    reg_wr_data_reg,  reg_wr_data_next;
    logic           bus_grant_reg,    bus_grant_next;
    logic           op_ready_reg,     op_ready_next;
    logic           irq_mask_reg,     irq_mask_next;
    logic           periph_reset_reg, periph_reset_next;
    proc_state_type proc_state_reg,   proc_state_next;

    ptr_sel_type    gen_sel;
    logic [7:0]     gen_field;
    logic [31:0]    gen_addr;
    logic           gen_long;
    logic [31:0]    lea_result;
    logic           is_ext_op;

    ptr_address_gen u_ptr_gen (
        .cpu_mode        (cpu_mode),
        .sel             (gen_sel),
        .field           (gen_field),
        .vector_base_reg (vector_base_reg),
        .ptr_addr        (gen_addr),
        .ptr_long        (gen_long)
    );

    lea_unit u_lea (
        .cpu_mode    (cpu_mode),
        .reg_operand (lea_index),
        .disp        (lea_disp),
        .scale       (lea_scale),
        .ea          (lea_result)
    );

    // Pointer generator select, kept apart from the sequencer to avoid a feedback path
    always_comb
    begin
        is_ext_op = (op_kind == OP_JUMP_EXT7) || (op_kind == OP_CALL_EXT7);
        gen_sel   = PTR_VECTOR;
        gen_field = exc_vector;
        if (state_reg == ST_RESET)
        begin
            gen_field = VEC_RESET;
        end
        else if (state_reg == ST_EXECUTE && !exc_req)
        begin
            gen_sel   = is_ext_op ? PTR_EXT7 : PTR_IND8;
            gen_field = op_field;
        end
    end

    always_comb
    begin
        state_next        = state_reg;
        pc_next           = pc_reg;
        mem_addr_next     = mem_addr_reg;
        mem_long_next     = mem_long_reg;
        ptr_ext_next      = ptr_ext_reg;
        branch_call_next  = branch_call_reg;
        branch_valid_next = 1'b0;
        reg_wr_en_next    = 1'b0;
        reg_wr_idx_next   = reg_wr_idx_reg;
        reg_wr_data_next  = reg_wr_data_reg;
        case (state_reg)
            ST_RESET:
            begin
                // Leaving reset loads the fixed reset vector address
                state_next    = ST_VEC_FETCH;
                mem_addr_next = gen_addr;
                mem_long_next = gen_long;
            end
            ST_VEC_FETCH:
            begin
                if (mem_ack)
                begin
                    pc_next    = fmt_pointer(cpu_mode, mem_rdata);
                    state_next = ST_EXECUTE;
                end
            end
            ST_EXECUTE:
            begin
                if (exc_req)
                begin
                    state_next    = ST_VEC_FETCH;
                    mem_addr_next = gen_addr;
                    mem_long_next = gen_long;
                end
                else if (bus_req)
                begin
                    state_next = ST_BUS_RELEASED;
                end
                else if (sleep_req || hw_standby)
                begin
                    state_next = ST_STOP;
                end
                else if (op_valid && op_ready_reg)
                begin
                    if (op_kind == OP_LEA)
                    begin
                        reg_wr_en_next   = 1'b1;
                        reg_wr_idx_next  = lea_dst;
                        reg_wr_data_next = lea_result;
                        pc_next          = trunc_ea(cpu_mode, pc_reg + {28'h0, op_len});
                    end
                    else
                    begin
                        state_next       = ST_PTR_FETCH;
                        mem_addr_next    = gen_addr;
                        mem_long_next    = gen_long;
                        ptr_ext_next     = is_ext_op;
                        branch_call_next = (op_kind == OP_CALL_IND8) || (op_kind == OP_CALL_EXT7);
                    end
                end
            end
            ST_PTR_FETCH:
            begin
                if (mem_ack)
                begin
                    pc_next           = fmt_pointer(cpu_mode, mem_rdata);
                    branch_valid_next = 1'b1;
                    state_next        = ST_EXECUTE;
                end
            end
            ST_BUS_RELEASED:
            begin
                if (!bus_req)
                begin
                    state_next = ST_EXECUTE;
                end
            end
            ST_STOP:
            begin
                // Standby only ends through reset; sleep wakes on an exception
                if (exc_req && !hw_standby)
                begin
                    state_next    = ST_VEC_FETCH;
                    mem_addr_next = gen_addr;
                    mem_long_next = gen_long;
                end
            end
            default:
            begin
                state_next = ST_RESET;
            end
        endcase
        if (wdt_overflow)
        begin
            // An op or fetch ending in the same cycle loses its register write and branch_valid, but pc_next still updates
            state_next        = ST_RESET;
            reg_wr_en_next    = 1'b0;
            branch_valid_next = 1'b0;
        end
        mem_req_next      = (state_next == ST_VEC_FETCH) || (state_next == ST_PTR_FETCH);
        bus_grant_next    = (state_next == ST_BUS_RELEASED);
        op_ready_next     = (state_next == ST_EXECUTE);
        irq_mask_next     = (state_next == ST_RESET);
        periph_reset_next = (state_next == ST_RESET);
        case (state_next)
            ST_RESET:        proc_state_next = PS_RESET;
            ST_VEC_FETCH:    proc_state_next = PS_EXCEPTION;
            ST_BUS_RELEASED: proc_state_next = PS_BUS_RELEASED;
            ST_STOP:         proc_state_next = PS_STOP;
            default:         proc_state_next = PS_EXECUTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg        <= ST_RESET;
            pc_reg           <= PC_RESET;
            mem_addr_reg     <= 32'h0000_0000;
            mem_long_reg     <= 1'b0;
            mem_req_reg      <= 1'b0;
            ptr_ext_reg      <= 1'b0;
            branch_call_reg  <= 1'b0;
            branch_valid_reg <= 1'b0;
            reg_wr_en_reg    <= 1'b0;
            reg_wr_idx_reg   <= 4'h0;
            reg_wr_data_reg  <= 32'h0000_0000;
            bus_grant_reg    <= 1'b0;
            op_ready_reg     <= 1'b0;
            irq_mask_reg     <= 1'b1;
            periph_reset_reg <= 1'b1;
            proc_state_reg   <= PS_RESET;
        end
        else
        begin
            state_reg        <= state_next;
            pc_reg           <= pc_next;
            mem_addr_reg     <= mem_addr_next;
            mem_long_reg     <= mem_long_next;
            mem_req_reg      <= mem_req_next;
            ptr_ext_reg      <= ptr_ext_next;
            branch_call_reg  <= branch_call_next;
            branch_valid_reg <= branch_valid_next;
            reg_wr_en_reg    <= reg_wr_en_next;
            reg_wr_idx_reg   <= reg_wr_idx_next;
            reg_wr_data_reg  <= reg_wr_data_next;
            bus_grant_reg    <= bus_grant_next;
            op_ready_reg     <= op_ready_next;
            irq_mask_reg     <= irq_mask_next;
            periph_reset_reg <= periph_reset_next;
            proc_state_reg   <= proc_state_next;
        end
    end

    assign op_ready     = op_ready_reg;
    assign mem_req      = mem_req_reg;
    assign mem_addr     = mem_addr_reg;
    assign mem_long     = mem_long_reg;
    assign bus_grant    = bus_grant_reg;
    assign branch_valid = branch_valid_reg;
    assign branch_call  = branch_call_reg;
    assign pc           = pc_reg;
    assign reg_wr_en    = reg_wr_en_reg;
    assign reg_wr_idx   = reg_wr_idx_reg;
    assign reg_wr_data  = reg_wr_data_reg;
    assign irq_mask     = irq_mask_reg;
    assign periph_reset = periph_reset_reg;
    assign proc_state   = proc_state_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    reset_exit_fetch_a: assert property (state_reg == ST_RESET && !wdt_overflow |=>
        mem_req_reg && mem_addr_reg == 32'h0000_0000 && proc_state_reg == PS_EXCEPTION)
        else $error("reset release did not fetch the reset vector");
    reset_irq_mask_a: assert property (irq_mask_reg == (proc_state_reg == PS_RESET))
        else $error("interrupt mask differs from reset state");
    reset_periph_hold_a: assert property (periph_reset_reg == (state_reg == ST_RESET))
        else $error("peripheral hold differs from reset state");
    watchdog_reset_a: assert property (wdt_overflow |=> state_reg == ST_RESET && irq_mask_reg)
        else $error("watchdog overflow did not reset");
    ind8_range_a: assert property (mem_req_reg && state_reg == ST_PTR_FETCH && !ptr_ext_reg
        |-> mem_addr_reg[31:8] == 24'h000000)
        else $error("memory-indirect pointer outside 0 to 255");
    ext7_range_a: assert property (mem_req_reg && state_reg == ST_PTR_FETCH && ptr_ext_reg
        |-> (is_normal(cpu_mode) ? (mem_addr_reg >= 32'h100 && mem_addr_reg <= 32'h1fe)
                                 : (mem_addr_reg >= 32'h200 && mem_addr_reg <= 32'h3fc)))
        else $error("extended pointer outside its table");
    ext7_address_a: assert property (state_reg == ST_EXECUTE && op_valid && op_ready_reg
        && is_ext_op && !exc_req && !bus_req && !sleep_req && !hw_standby && !wdt_overflow
        |=> mem_addr_reg == scale_ptr(cpu_mode, {25'h0, $past(op_field[6:0])} + EXT7_OFFSET))
        else $error("extended pointer address wrong");
    ptr_size_a: assert property (mem_req_reg |-> mem_long_reg == !is_normal(cpu_mode))
        else $error("pointer fetch size wrong for mode");
    target_top_byte_a: assert property (branch_valid_reg && (cpu_mode == MODE_MIDDLE
        || cpu_mode == MODE_ADVANCED) |-> pc_reg[31:24] == 8'h00)
        else $error("branch target top byte not cleared");
    normal_trunc_a: assert property (is_normal(cpu_mode) && reg_wr_en_reg
        |-> reg_wr_data_reg[31:16] == 16'h0000 && pc_reg[31:16] == 16'h0000)
        else $error("normal mode address not truncated");
    lea_no_access_a: assert property (reg_wr_en_reg |-> !mem_req_reg && state_reg == ST_EXECUTE)
        else $error("address load started a memory access");
    bus_release_a: assert property (state_reg == ST_EXECUTE && bus_req && !exc_req
        && !wdt_overflow |=> bus_grant_reg && !op_ready_reg)
        else $error("bus request not honoured");
    stop_halts_a: assert property (state_reg == ST_STOP |-> !op_ready_reg && !mem_req_reg)
        else $error("execution continued in stop state");
    vector_to_exec_a: assert property (state_reg == ST_VEC_FETCH && mem_ack && !wdt_overflow
        |=> op_ready_reg && pc_reg == fmt_pointer(cpu_mode, $past(mem_rdata)))
        else $error("vector load did not start execution");

    reset_vector_c: cover property (state_reg == ST_VEC_FETCH && mem_ack ##1 op_ready_reg);
    indirect_call_c: cover property (branch_valid_reg && branch_call_reg);
    bus_cycle_c: cover property (bus_grant_reg ##1 !bus_grant_reg);
    sleep_wake_c: cover property (state_reg == ST_STOP ##1 state_reg == ST_VEC_FETCH);
endmodule : cpu_indirect_branch_and_state_control
`default_nettype wire

/* File: test/mem_model.sv */
// Memory model holding branch pointers and vectors
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
    input  wire logic        core_clk,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [1:0]  wait_cycles,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [1:0] cnt = 2'h0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
    end
    // Idle data flips every cycle so a stale read never matches
    always @(negedge core_clk)
    begin
        if (mem_req && !mem_ack && cnt >= wait_cycles)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= {~mem_addr[15:0], mem_addr[15:0] + 16'h1234};
            cnt <= 2'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule : mem_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the branch and state control core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpu_branch_pkg::*;
    cpu_mode_type   cpu_mode = MODE_NORMAL;
    op_kind_type    op_kind = OP_LEA;
    proc_state_type proc_state;
    logic [31:0] vector_base_reg = 0, lea_index = 0, lea_disp = 0, mem_addr, mem_rdata, pc;
    logic [31:0] reg_wr_data, seed = 32'h3c55;
    logic [7:0]  exc_vector = 0, op_field = 0;
    logic [3:0]  op_len = 4'h2, lea_dst = 0, reg_wr_idx;
    logic [1:0]  lea_scale = 0, wait_cycles = 0;
    logic core_clk = 0, rst_n = 0, wdt_overflow = 0, exc_req = 0, op_valid = 0, bus_req = 0;
    logic sleep_req = 0, hw_standby = 0, op_ready, mem_req, mem_long, bus_grant, mem_ack;
    logic branch_valid, branch_call, reg_wr_en, irq_mask, periph_reset;
    int   fail_count = 0, checks = 0, cycles = 0;
    always #2.5 core_clk = ~core_clk;
    cpu_indirect_branch_and_state_control i_cpu_indirect_branch_and_state_control
    (
        .core_clk, .rst_n, .cpu_mode, .wdt_overflow, .exc_req, .exc_vector, .vector_base_reg,
        .op_valid, .op_kind, .op_field, .op_len, .lea_index, .lea_disp, .lea_scale, .lea_dst,
        .mem_ack, .mem_rdata, .bus_req, .sleep_req, .hw_standby, .op_ready, .mem_req,
        .mem_addr, .mem_long, .bus_grant, .branch_valid, .branch_call, .pc, .reg_wr_en,
        .reg_wr_idx, .reg_wr_data, .irq_mask, .periph_reset, .proc_state
    );
    mem_model i_mem_model (.core_clk, .mem_req, .mem_addr, .wait_cycles, .mem_ack, .mem_rdata);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] tgt(input logic [31:0] a);
        logic [31:0] d;
        d = {~a[15:0], a[15:0] + 16'h1234};
        if (cpu_mode == MODE_NORMAL)
            return d & 32'hffff;
        return (cpu_mode == MODE_MAXIMUM) ? d : d & 32'hffffff;
    endfunction : tgt
    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // Bounded wait so a missing handshake shows as a mismatch, not a hang
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 30 && s !== 1'b1; n++)
            @(negedge core_clk);
    endtask : wait_hi
    task automatic do_reset(input cpu_mode_type m);
        rst_n = 1'b0;
        cpu_mode = m;
        repeat (5) @(negedge core_clk);
        chk({proc_state, irq_mask, periph_reset}, {PS_RESET, 2'b11});
        rst_n = 1'b1;
        @(negedge core_clk);
        chk({proc_state, mem_req, mem_addr}, {PS_EXCEPTION, 1'b1, 32'h0});
        wait_hi(op_ready);
        chk({proc_state, pc}, {PS_EXECUTE, tgt(0)});
    endtask : do_reset
    task automatic branch(input op_kind_type k, input logic [7:0] f);
        logic [31:0] a;
        a = (32'(f[6:0]) + 32'h80) << ((cpu_mode == MODE_NORMAL) ? 1 : 2);
        if (k < OP_JUMP_EXT7)
            a = {24'h0, f};
        @(negedge core_clk);
        wait_hi(op_ready);
        op_valid = 1'b1;
        op_kind = k;
        op_field = f;
        @(negedge core_clk);
        op_valid = 1'b0;
        chk({mem_req, mem_long, mem_addr}, {1'b1, cpu_mode != MODE_NORMAL, a});
        wait_hi(branch_valid);
        chk({branch_valid, branch_call, pc}, {1'b1, k[0], tgt(a)});
    endtask : branch
    task automatic lea();
        logic [31:0] e, p;
        lea_index = rnd();
        lea_disp = rnd();
        lea_scale = 2'(rnd());
        lea_dst = 4'(rnd());
        op_len = 4'(rnd());
        e = lea_disp + (lea_index << lea_scale);
        p = pc + 32'(op_len);
        if (cpu_mode == MODE_NORMAL)
        begin
            e &= 32'hffff;
            p &= 32'hffff;
        end
        wait_hi(op_ready);
        op_valid = 1'b1;
        op_kind = OP_LEA;
        @(negedge core_clk);
        op_valid = 1'b0;
        chk({reg_wr_en, mem_req, reg_wr_idx, reg_wr_data}, {2'b10, lea_dst, e});
        chk(pc, p);
    endtask : lea
    task automatic exc(input logic [7:0] v);
        logic [31:0] a;
        a = (32'(v) << ((cpu_mode == MODE_NORMAL) ? 1 : 2)) + ((v == 8'h09) ? 0 : vector_base_reg);
        wait_hi(op_ready);
        exc_req = 1'b1;
        exc_vector = v;
        @(negedge core_clk);
        exc_req = 1'b0;
        chk({proc_state, mem_addr}, {PS_EXCEPTION, a});
        wait_hi(op_ready);
        chk(pc, tgt(a));
    endtask : exc
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            do_reset(cpu_mode_type'(m));
            vector_base_reg = rnd() & 32'h7ffc;
            branch(OP_JUMP_IND8, 8'hff);
            branch(OP_CALL_EXT7, 8'hff);
            for (int i = 0; i < 12; i++)
            begin
                wait_cycles = 2'(rnd());
                branch(op_kind_type'(rnd() % 4), 8'(rnd()));
                lea();
            end
            exc(8'h09);
            exc(8'(rnd()) | 8'h02);
            wait_hi(op_ready);
            bus_req = 1'b1;
            @(negedge core_clk);
            chk({bus_grant, op_ready, proc_state}, {2'b10, PS_BUS_RELEASED});
            repeat (3) @(negedge core_clk);
            bus_req = 1'b0;
            @(negedge core_clk);
            chk({bus_grant, op_ready}, 2'b01);
            sleep_req = m[0];
            hw_standby = !m[0];
            @(negedge core_clk);
            sleep_req = 1'b0;
            chk({proc_state, op_ready}, {PS_STOP, 1'b0});
            exc_req = 1'b1;
            @(negedge core_clk);
            exc_req = 1'b0;
            chk(proc_state, m[0] ? PS_EXCEPTION : PS_STOP);
            wdt_overflow = 1'b1;
            hw_standby = 1'b0;
            @(negedge core_clk);
            wdt_overflow = 1'b0;
            chk({proc_state, irq_mask}, {PS_RESET, 1'b1});
            @(negedge core_clk);
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
